// ### hw/pcod_top.sv
// Programmable clock output divider: register, mode control and pin drive
//
// What this block does
// - Eight-bit factor; output frequency is CPU clock over factor plus one.
// - With clock output enabled and factor zero, undivided CPU clock drives port 3 pin 15.
// - Factor writes accepted only with both peripheral enables set.
// - With clock output enabled and a nonzero factor programmed, the prescaled clock drives the pin.
// - With clock output disabled, no clock drives the pin at all.
// - Divider register reachable on the internal peripheral bus.
//
// The pin clock is carried as two phase bits per system cycle: the value
// for the high half and for the low half of clk_sys. The pad output cell
// selects between them with clk_sys, which is the only way a registered
// output can reproduce the full CPU clock rate.
//
// Limitations worth knowing:
// - The two peripheral enables are plain level inputs here; their own
//   registers live with the system configuration logic.
// - A new nonzero factor only takes effect at the end of the running period, so
//   a slow factor can delay the change by up to 256 cycles.
// - Factor zero selects the pass-through mode, where the core counter is
//   idle and the pad sees high then low in every CPU cycle.
// - A refused write leaves the old factor in place and raises a sticky
//   status bit; reading the status word clears it again.
// - Status layout: bit 0 output active, bit 1 dividing, bit 2 factor
//   written since reset, bit 3 write refused, bits 15:8 core counter.
`timescale 1ns/1ps
`include "pcod_cfg.svh"
module pcod_top
  import pcod_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic                     clock_output_enable,
  input  wire logic                     misc_peripheral_enable,
  input  wire logic                     peripheral_bus_enable,
  input  wire logic                     periph_sel,
  input  wire logic                     periph_wr,
  input  wire logic                     periph_rd,
  input  wire logic [`PCOD_ADDR_W-1:0]  periph_addr,
  input  wire logic [`PCOD_DATA_W-1:0]  periph_wdata,
  output      logic [`PCOD_DATA_W-1:0]  periph_rdata,
  output      logic                     periph_ready,
  output      logic                     port3_pin15_hi,
  output      logic                     port3_pin15_lo,
  output      logic                     port3_pin15_oe
);

  logic         rst_meta_n;
  logic         rst_sync_n;
  pcod_factor_t clock_output_divider;
  logic         written;
  logic         refused;
  pcod_mode_t   mode;
  pcod_mode_t   next_mode;
  pcod_word_t   next_rdata;

  pcod_div_if   div ();

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Small helper: does a bus access hit a given offset
  function automatic logic pcod_hit(
    input logic [`PCOD_ADDR_W-1:0] addr,
    input logic [`PCOD_ADDR_W-1:0] offset
  );
    pcod_hit = (addr == offset);
  endfunction : pcod_hit

  // Address decode of the two registers
  // Only exact word offsets hit; byte lanes are not decoded on their own
  wire hit_div   = pcod_hit(periph_addr, `PCOD_DIV_OFFSET);
  wire hit_stat  = pcod_hit(periph_addr, `PCOD_STAT_OFFSET);
  wire wr_cycle  = periph_sel & periph_wr;
  wire rd_cycle  = periph_sel & periph_rd;
  wire access    = periph_sel & (periph_wr | periph_rd);

  // write gating
  // Both enables must be set; otherwise the write is dropped and noted
  wire prog_ok   = misc_peripheral_enable & peripheral_bus_enable;
  wire div_write = wr_cycle & hit_div & prog_ok;
  wire div_block = wr_cycle & hit_div & ~prog_ok;

  // Reading status clears the refused flag; a new refusal wins
  wire stat_read = rd_cycle & hit_stat;

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      clock_output_divider <= `PCOD_DIV_RESET;
    end else if (div_write) begin
      clock_output_divider <= periph_wdata[`PCOD_DIV_MSB:`PCOD_DIV_LSB];
    end
  end

  // programmed flag
  // Kept for software to see that a factor has been taken
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      written <= 1'b0;
    end else if (div_write) begin
      written <= 1'b1;
    end
  end

  // Sticky refused-write flag, set has priority over clear on read
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      refused <= 1'b0;
    end else if (div_block) begin
      refused <= 1'b1;
    end else if (stat_read) begin
      refused <= 1'b0;
    end
  end

  // Mode selection from enable and stored factor
  always_comb begin
    next_mode = PCOD_OFF;
    if (clock_output_enable) begin
      if (clock_output_divider == 8'h00) begin
        next_mode = PCOD_PASS;
      end else begin
        next_mode = PCOD_DIVIDE;
      end
    end
  end

  // Mode register; one cycle between the enable pin and the mode
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode <= PCOD_OFF;
    end else begin
      mode <= next_mode;
    end
  end

  // Divider core runs only while the output is enabled
  assign div.run    = (mode != PCOD_OFF);
  assign div.factor = clock_output_divider;

  pcod_div_core u_core (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .div        (div.core)
  );

  // Read data selection; unmapped offsets read as zero
  always_comb begin
    next_rdata = 16'h0000;
    if (hit_div) begin
      next_rdata[`PCOD_DIV_MSB:`PCOD_DIV_LSB] = clock_output_divider;
    end else if (hit_stat) begin
      next_rdata[`PCOD_STAT_ACTIVE]   = (mode != PCOD_OFF);
      next_rdata[`PCOD_STAT_DIVIDING] = (mode == PCOD_DIVIDE);
      next_rdata[`PCOD_STAT_WRITTEN]  = written;
      next_rdata[`PCOD_STAT_REFUSED]  = refused;
      next_rdata[15:`PCOD_STAT_PHASE_LSB] = div.count;
    end
  end

  // Bus answer one cycle after the access, read data held until next read
  // Writes are answered too, so a refused write still completes on the bus
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      periph_rdata <= 16'h0000;
      periph_ready <= 1'b0;
    end else begin
      periph_ready <= access;
      if (rd_cycle) begin
        periph_rdata <= next_rdata;
      end
    end
  end

  // Pin drive registers
  // The enable and phases are registered together so the pad never sees
  // a half-updated combination when the mode changes
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      port3_pin15_hi <= 1'b0;
      port3_pin15_lo <= 1'b0;
      port3_pin15_oe <= 1'b0;
    end else begin
      unique case (mode)
        PCOD_OFF: begin
          port3_pin15_hi <= 1'b0;
          port3_pin15_lo <= 1'b0;
          port3_pin15_oe <= 1'b0;
        end
        PCOD_PASS: begin
          port3_pin15_hi <= 1'b1;
          port3_pin15_lo <= 1'b0;
          port3_pin15_oe <= 1'b1;
        end
        PCOD_DIVIDE: begin
          port3_pin15_hi <= div.phase_hi;
          port3_pin15_lo <= div.phase_lo;
          port3_pin15_oe <= 1'b1;
        end
        // Illegal one-hot codes fall back to a released pin
        default: begin
          port3_pin15_hi <= 1'b0;
          port3_pin15_lo <= 1'b0;
          port3_pin15_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule : pcod_top

// ### hw/pcod_cfg.svh
// Offsets, field positions and reset values of the clock output divider
`ifndef PCOD_CFG_SVH
`define PCOD_CFG_SVH

// Peripheral bus geometry
`define PCOD_ADDR_W         16
`define PCOD_DATA_W         16

// Register offsets inside the miscellaneous peripheral range
`define PCOD_DIV_OFFSET     16'h0040
`define PCOD_STAT_OFFSET    16'h0042

// Divide-factor field of clock_output_divider
`define PCOD_DIV_W          8
`define PCOD_DIV_LSB        0
`define PCOD_DIV_MSB        7
`define PCOD_DIV_RESET      8'h00

// Status register bit positions
`define PCOD_STAT_ACTIVE    0
`define PCOD_STAT_DIVIDING  1
`define PCOD_STAT_WRITTEN   2
`define PCOD_STAT_REFUSED   3
`define PCOD_STAT_PHASE_LSB 8

`endif

// ### hw/pcod_pkg.sv
// Types shared by the clock output divider modules
package pcod_pkg;

  // Output mode, one-hot
  typedef enum logic [2:0] {
    PCOD_OFF    = 3'b001,
    PCOD_PASS   = 3'b010,
    PCOD_DIVIDE = 3'b100
  } pcod_mode_t;

  typedef logic [7:0]  pcod_factor_t;
  typedef logic [15:0] pcod_word_t;

endpackage : pcod_pkg

// ### hw/pcod_div_if.sv
// Signals between the register side and the divider core
`timescale 1ns/1ps
interface pcod_div_if;
  import pcod_pkg::*;

  logic         run;
  pcod_factor_t factor;
  logic         phase_hi;
  logic         phase_lo;
  pcod_factor_t count;

  modport ctrl (output run, output factor,
                input  phase_hi, input phase_lo, input count);
  modport core (input  run, input factor,
                output phase_hi, output phase_lo, output count);
endinterface : pcod_div_if

// ### hw/pcod_div_core.sv
// Counter that builds the two clock phases of the divided clock
`timescale 1ns/1ps
`include "pcod_cfg.svh"
module pcod_div_core
  import pcod_pkg::*;
(
  input wire logic  clk_sys,
  input wire logic  rst_sync_n,
  pcod_div_if.core  div
);

  pcod_factor_t cnt;
  pcod_factor_t cur;
  logic         phase_hi;
  logic         phase_lo;

  // Half-cycle indices of the current cycle against the half period
  wire       last_cnt    = (cnt == cur);
  wire [8:0] half_period = {1'b0, cur} + 9'h001;
  wire [8:0] idx_hi      = {cnt, 1'b0};
  wire [8:0] idx_lo      = {cnt, 1'b1};
  wire       next_hi     = (idx_hi < half_period);
  wire       next_lo     = (idx_lo < half_period);

  // reloading counter
  // While running, a new factor is only taken at the period boundary, so no runt pulse
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt <= 8'h00;
      cur <= `PCOD_DIV_RESET;
    end else if (!div.run) begin
      cnt <= 8'h00;
      cur <= div.factor;
    end else if (last_cnt) begin
      cnt <= 8'h00;
      cur <= div.factor;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // phase registers
  // Factor zero gives high then low in one cycle: the clock itself
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phase_hi <= 1'b0;
      phase_lo <= 1'b0;
    end else begin
      phase_hi <= div.run & next_hi;
      phase_lo <= div.run & next_lo;
    end
  end

  assign div.phase_hi = phase_hi;
  assign div.phase_lo = phase_lo;
  assign div.count    = cnt;

endmodule : pcod_div_core

// ### verif/pcod_pin_sink.sv
// Consumer of the pin clock: counts rising edges and high halves
`timescale 1ns/1ps
module pcod_pin_sink (
  input  wire logic        clk_sys,
  input  wire logic        hi,
  input  wire logic        lo,
  input  wire logic        oe,
  output      logic [15:0] rises = 16'h0000,
  output      logic [15:0] highs = 16'h0000
);
  logic last = 1'b0;
  // edge and duty count
  // A released pin is read low, as through a pull-down
  always @(posedge clk_sys) begin
    rises <= rises + 16'(oe & hi & !last) + 16'(oe & lo & !hi);
    highs <= highs + 16'(oe & hi) + 16'(oe & lo);
    last  <= oe & lo;
  end
endmodule : pcod_pin_sink

// ### verif/pcod_top_sva.sv
// Port checker for the clock output divider
`timescale 1ns/1ps
`include "pcod_cfg.svh"
module pcod_top_sva (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        clock_output_enable,
  input wire logic        misc_peripheral_enable,
  input wire logic        peripheral_bus_enable,
  input wire logic        periph_sel,
  input wire logic        periph_wr,
  input wire logic        periph_rd,
  input wire logic [15:0] periph_addr,
  input wire logic [15:0] periph_wdata,
  input wire logic [15:0] periph_rdata,
  input wire logic        periph_ready,
  input wire logic        port3_pin15_hi,
  input wire logic        port3_pin15_lo,
  input wire logic        port3_pin15_oe
);
  logic [7:0] shadow;
  logic [8:0] sc;
  logic [2:0] up;
  wire acc  = periph_sel & (periph_wr | periph_rd);
  wire adiv = periph_addr == `PCOD_DIV_OFFSET;
  wire take = acc & periph_wr & adiv & misc_peripheral_enable
    & peripheral_bus_enable;
  wire setl = sc == 9'h12c && port3_pin15_oe;
  // Accepted factor and its age; 300 cycles outlasts any old period
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shadow <= `PCOD_DIV_RESET;
      sc     <= 9'h000;
      up     <= 3'h0;
    end else begin
      if (take) shadow <= periph_wdata[7:0];
      sc <= take ? 9'h000 : sc + 9'(sc != 9'h12c);
      up <= up + 3'(up != 3'h7);
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_ready_follows:
  assert property (acc |=> periph_ready) else $error("ready missing");
  chk_ready_idle:
  assert property (!acc |=> !periph_ready) else $error("stray ready");
  chk_factor_back:
  assert property (acc & periph_rd & adiv |=>
    periph_rdata == {8'h00, $past(shadow)}) else $error("bad factor");
  chk_unmapped_zero:
  assert property (acc & periph_rd & !adiv & periph_addr !=
    `PCOD_STAT_OFFSET |=> periph_rdata == 16'h0000) else $error("bad hole");
  chk_oe_cause:
  assert property (port3_pin15_oe |-> $past(clock_output_enable, 2))
    else $error("pin driven while disabled");
  chk_oe_on:
  assert property (up == 3'h7 && $past(clock_output_enable, 2)
    |-> port3_pin15_oe) else $error("pin not driven");
  chk_off_quiet:
  assert property (!port3_pin15_oe |-> !port3_pin15_hi && !port3_pin15_lo)
    else $error("phases while off");
  chk_pass_zero:
  assert property (setl && shadow == 8'h00 |-> port3_pin15_hi
    && !port3_pin15_lo) else $error("no passthrough");
  chk_div_fall:
  assert property (setl && shadow != 8'h00 && port3_pin15_hi
    && !port3_pin15_lo |=> !port3_pin15_hi) else $error("bad duty");
  cover property (acc & periph_wr & adiv & !take);
  cover property (setl && shadow == 8'hff);
  cover property ($fell(port3_pin15_oe));
endmodule : pcod_top_sva
bind pcod_top pcod_top_sva u_sva (.*);

// ### verif/programmable_clock_output_divider_tb.sv
// Self-checking bench for the clock output divider
`timescale 1ns/1ps
`include "pcod_cfg.svh"
module programmable_clock_output_divider_tb;
  logic clk_sys = 1'b0, rst_n = 1'b0, en = 1'b0, misc = 1'b0, pbe = 1'b0;
  logic sel = 1'b0, wr = 1'b0, rd = 1'b0, ready, hi, lo, oe;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000;
  logic [15:0] rdata, rises, highs, r0, h0;
  logic [16:0] seed = 17'h103ad;
  logic [7:0]  f;
  int          n_mismatch = 0;
  int          n_compared = 0;
  pcod_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .clock_output_enable(en), .misc_peripheral_enable(misc),
    .peripheral_bus_enable(pbe), .periph_sel(sel), .periph_wr(wr),
    .periph_rd(rd), .periph_addr(addr), .periph_wdata(wdata),
    .periph_rdata(rdata), .periph_ready(ready), .port3_pin15_hi(hi),
    .port3_pin15_lo(lo), .port3_pin15_oe(oe));
  pcod_pin_sink u_sink (.clk_sys(clk_sys), .hi(hi), .lo(lo), .oe(oe),
    .rises(rises), .highs(highs));
  initial forever #5 clk_sys = ~clk_sys;
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : lfsr
  // Expected high halves over two periods of factor n
  function automatic logic [15:0] exp_highs(input logic [7:0] n);
    return 16'(2 * (n + 1));
  endfunction : exp_highs
  // Expected status word; the counter field reads zero while idle
  function automatic logic [15:0] exp_stat(input logic a, v, w, r);
    logic [15:0] s;
    s = 16'h0000;
    s[`PCOD_STAT_ACTIVE]   = a;
    s[`PCOD_STAT_DIVIDING] = v;
    s[`PCOD_STAT_WRITTEN]  = w;
    s[`PCOD_STAT_REFUSED]  = r;
    return s;
  endfunction : exp_stat
  task automatic chk(input string w, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", w, exp, seen);
    end
  endtask : chk
  // One access; the strobe drops right after the taking edge
  task automatic bus(input logic w, input logic [15:0] a, d);
    @(posedge clk_sys);
    sel   <= 1'b1;
    wr    <= w;
    rd    <= !w;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    sel <= 1'b0;
    wr  <= 1'b0;
    rd  <= 1'b0;
    #1 chk("ready", 16'(ready), 16'h0001);
  endtask : bus
  task automatic rd_chk(input logic [15:0] a, e);
    bus(1'b0, a, 16'h0000);
    chk("rdata", rdata, e);
  endtask : rd_chk
  // Two periods after settling: two rising edges, half the halves high
  task automatic measure(input logic [7:0] n);
    repeat (300) @(posedge clk_sys);
    #1 r0 = rises;
    h0 = highs;
    repeat (2 * (n + 1)) @(posedge clk_sys);
    #1 chk("rises", rises - r0, 16'h0002);
    chk("highs", highs - h0, exp_highs(n));
  endtask : measure
  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // Hang guard: a stuck run ends as a failure
  initial begin
    #500000;
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    en <= 1'b1;
    rd_chk(`PCOD_DIV_OFFSET, 16'h0000);
    rd_chk(16'h0080, 16'h0000);
    measure(8'h00);
    // Writes with one or no enable set must be dropped
    bus(1'b1, `PCOD_DIV_OFFSET, 16'h0055);
    @(posedge clk_sys);
    misc <= 1'b1;
    bus(1'b1, `PCOD_DIV_OFFSET, 16'h0055);
    rd_chk(`PCOD_DIV_OFFSET, 16'h0000);
    // Refusal is sticky until the status word has been read once
    rd_chk(`PCOD_STAT_OFFSET, exp_stat(1'b1, 1'b0, 1'b0, 1'b1));
    rd_chk(`PCOD_STAT_OFFSET, exp_stat(1'b1, 1'b0, 1'b0, 1'b0));
    @(posedge clk_sys);
    pbe <= 1'b1;
    // Hand-picked and random factors, odd bits above the field
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      f = (i < 3) ? 8'(i) : (i == 5) ? 8'hff : seed[7:0];
      bus(1'b1, `PCOD_DIV_OFFSET, {seed[15:8], f});
      rd_chk(`PCOD_DIV_OFFSET, {8'h00, f});
      measure(f);
    end
    @(posedge clk_sys);
    en <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk("pin", 16'({oe, hi, lo}), 16'h0000);
    rd_chk(`PCOD_STAT_OFFSET, exp_stat(1'b0, 1'b0, 1'b1, 1'b0));
    // Reset with the clock output disabled clears the factor and the status flags
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd_chk(`PCOD_DIV_OFFSET, 16'h0000);
    rd_chk(`PCOD_STAT_OFFSET, 16'h0000);
    summarize();
  end
endmodule : programmable_clock_output_divider_tb
